// file: rtl/devcap_defines.vh
/*
 * Offsets, field positions, reset values and codes for the device
 * capabilities register bank.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DEVCAP_DEFINES_VH
`define DEVCAP_DEFINES_VH

// ******************************
// register offsets
// ******************************
`define DEVCAP_OFF_CAP        12'h044
`define DEVCAP_OFF_CTRL       12'h100
`define DEVCAP_OFF_STATUS     12'h104

// ******************************
// field positions
// ******************************
`define DEVCAP_MPS_LSB        0
`define DEVCAP_MPS_MSB        2
`define DEVCAP_PFS_LSB        3
`define DEVCAP_PFS_MSB        4
`define DEVCAP_EXTENDED_TAG_SUPPORT_BIT       5
`define DEVCAP_L0S_LSB        6
`define DEVCAP_L0S_MSB        8
`define DEVCAP_L1_LSB         9
`define DEVCAP_L1_MSB         11
`define DEVCAP_ABP_BIT        12
`define DEVCAP_AIP_BIT        13
`define DEVCAP_PIP_BIT        14
`define DEVCAP_RBER_BIT       15
`define DEVCAP_PLV_LSB        18
`define DEVCAP_PLV_MSB        25
`define DEVCAP_PLS_LSB        26
`define DEVCAP_PLS_MSB        27
`define DEVCAP_CTRL_LOCK_BIT  0

// ******************************
// reset values and codes
// ******************************
`define DEVCAP_MPS_RESET      3'h4
`define DEVCAP_EXTENDED_TAG_SUPPORT_RESET     1'h1
`define DEVCAP_RBER_VALUE     1'h1
`define DEVCAP_TYPE_UP        4'h5
`define DEVCAP_TYPE_DOWN      4'h6

// ******************************
// timing counts
// ******************************
// edges after release before the synchronised strap is trusted
`define DEVCAP_STRAP_SETTLE   3'h4

`endif

// file: rtl/input_sync.v
/*
 * Three-stage synchroniser for a bus of asynchronous inputs; a change
 * is accepted once the second and third stages agree.
 * Assumes clock and asynchronous active-high rst.
 */
`timescale 1ns/1ps

module input_sync #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] s1_r;
reg [WIDTH-1:0] s2_r;
reg [WIDTH-1:0] s3_r;

// ******************************
// sync chain
// ******************************
// stage one only feeds stage two, to keep metastability contained
always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        s1_r <= {WIDTH{1'b0}};
        s2_r <= {WIDTH{1'b0}};
        s3_r <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
        s1_r <= async_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r)
            sync_out <= s3_r;
    end
end

endmodule // input_sync

// file: rtl/device_capabilities_reg.v
/*
 * Device capabilities register of one switch port, behind an APB slave,
 * with capture of the slot power limit from the upstream link.
 * Assumes the link logic gives a one-cycle message strobe with value and
 * scale on the core clock, and a port type strap on a pin.
 */
// The implementer's own choice: the APB slave port.
// Notes on behaviour
// - Bits 2:0 report the largest payload supported, reset by hardware to 4 (2048 bytes).
// - Bits 4:3 phantom function support always read zero.
// - Bit 5 extended tag support resets to one and is writable only when the lock is open.
// - Bits 8:6 L0s acceptable latency always read zero.
// - Bits 11:9 L1 acceptable latency always read zero.
// - Bits 12, 13 and 14 indicator and button presence always read zero.
// - Bit 15 reads one for role based error reporting.
// - The upstream port loads bits 25:18 from a slot power message; downstream reads zero.
// - The upstream port loads scale bits 27:26 from that message; downstream reads zero.
// - The port type strap is 5 for upstream and 6 for downstream and gates capture.
`timescale 1ns/1ps
`include "devcap_defines.vh"

module device_capabilities_reg #(
    parameter ADDR_WIDTH = 12
) (
    input wire clock,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [3:0] port_type_pin,
    input wire power_msg_valid,
    input wire [7:0] power_msg_value,
    input wire [1:0] power_msg_scale,
    output wire is_upstream
);

wire [3:0] port_type_sync;
reg [3:0] port_type_r;
reg strap_taken_r;
reg [2:0] settle_cnt_r;
reg [2:0] max_payload_supported_r;
reg extended_tag_support_r;
reg [7:0] captured_power_limit_value_r;
reg [1:0] captured_power_limit_scale_r;
reg lockable_write_access_r;
reg [31:0] rd_nxt;
reg hit_nxt;

// ******************************
// helpers
// ******************************
// decode an address against one register offset
function addr_hit;
    input [ADDR_WIDTH-1:0] a;
    input [11:0] off;
    begin
        addr_hit = (a[11:2] == off[11:2]);
    end
endfunction

// ******************************
// port type strap
// ******************************
// the strap pin is asynchronous, so it passes the synchroniser first
input_sync #(
    .WIDTH(4)
) strap_sync (
    .clock(clock),
    .rst(rst),
    .async_in(port_type_pin),
    .sync_out(port_type_sync)
);

// high once the sync chain has had time to pass the strap through
wire strap_settled = (settle_cnt_r == `DEVCAP_STRAP_SETTLE);

// the sync output shows its reset value for a few edges after release, and
// latching it then would give a downstream port whatever the strap pin says
always @(posedge clock or posedge rst)
begin
    if (rst)
        settle_cnt_r <= 3'h0;
    else if (!strap_settled)
        settle_cnt_r <= settle_cnt_r + 3'h1;
end

// caught once, never in mid-transfer; a strap other than the upstream code
// is taken as downstream, so a bad strap can never enable capture
always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        port_type_r <= `DEVCAP_TYPE_DOWN;
        strap_taken_r <= 1'b0;
    end
    else if (!strap_taken_r && strap_settled && !psel)
    begin
        if (port_type_sync == `DEVCAP_TYPE_UP)
            port_type_r <= `DEVCAP_TYPE_UP;
        else
            port_type_r <= `DEVCAP_TYPE_DOWN;
        strap_taken_r <= 1'b1;
    end
end

assign is_upstream = (port_type_r == `DEVCAP_TYPE_UP);

// ******************************
// apb handshake
// ******************************
// zero wait state; unmapped addresses answer with an error
assign pready = 1'b1;
assign pslverr = psel && penable && !hit_nxt;

wire wr_en = psel && penable && pwrite;

// writes land at the access edge; all writable bits sit in byte lane 0
wire cap_wr_en = wr_en && addr_hit(paddr, `DEVCAP_OFF_CAP) && lockable_write_access_r && pstrb[0];

// ******************************
// register state
// ******************************
// lock for the lockable fields, open only while software holds it set
always @(posedge clock or posedge rst)
begin
    if (rst)
        lockable_write_access_r <= 1'b0;
    else if (wr_en && addr_hit(paddr, `DEVCAP_OFF_CTRL) && pstrb[0])
        lockable_write_access_r <= pwdata[`DEVCAP_CTRL_LOCK_BIT];
end

// only the lockable fields take writes; the rest of the word ignores them
always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        max_payload_supported_r <= `DEVCAP_MPS_RESET;
        extended_tag_support_r <= `DEVCAP_EXTENDED_TAG_SUPPORT_RESET;
    end
    else if (cap_wr_en)
    begin
        max_payload_supported_r <= pwdata[`DEVCAP_MPS_MSB:`DEVCAP_MPS_LSB];
        extended_tag_support_r <= pwdata[`DEVCAP_EXTENDED_TAG_SUPPORT_BIT];
    end
end

// downstream ports never capture, so their power fields stay zero
always @(posedge clock or posedge rst)
begin
    if (rst)
    begin
        captured_power_limit_value_r <= 8'h00;
        captured_power_limit_scale_r <= 2'h0;
    end
    else if (power_msg_valid && is_upstream)
    begin
        captured_power_limit_value_r <= power_msg_value;
        captured_power_limit_scale_r <= power_msg_scale;
    end
end

// ******************************
// read mux
// ******************************
// hardwired fields other than bit 15, and reserved bits, are built in as zero; a message that
// lands during a read shows up on the next read, not the current one
always @*
begin
    rd_nxt = 32'h00000000;
    hit_nxt = 1'b1;
    if (addr_hit(paddr, `DEVCAP_OFF_CAP))
    begin
        rd_nxt[`DEVCAP_MPS_MSB:`DEVCAP_MPS_LSB] = max_payload_supported_r;
        rd_nxt[`DEVCAP_PFS_MSB:`DEVCAP_PFS_LSB] = 2'h0;
        rd_nxt[`DEVCAP_EXTENDED_TAG_SUPPORT_BIT] = extended_tag_support_r;
        rd_nxt[`DEVCAP_L0S_MSB:`DEVCAP_L0S_LSB] = 3'h0;
        rd_nxt[`DEVCAP_L1_MSB:`DEVCAP_L1_LSB] = 3'h0;
        rd_nxt[`DEVCAP_ABP_BIT] = 1'b0;
        rd_nxt[`DEVCAP_AIP_BIT] = 1'b0;
        rd_nxt[`DEVCAP_PIP_BIT] = 1'b0;
        rd_nxt[`DEVCAP_RBER_BIT] = `DEVCAP_RBER_VALUE;
        rd_nxt[`DEVCAP_PLV_MSB:`DEVCAP_PLV_LSB] = captured_power_limit_value_r;
        rd_nxt[`DEVCAP_PLS_MSB:`DEVCAP_PLS_LSB] = captured_power_limit_scale_r;
    end
    else if (addr_hit(paddr, `DEVCAP_OFF_CTRL))
        rd_nxt[`DEVCAP_CTRL_LOCK_BIT] = lockable_write_access_r;
    else if (addr_hit(paddr, `DEVCAP_OFF_STATUS))
    begin
        rd_nxt[3:0] = port_type_r;
        rd_nxt[4] = is_upstream;
    end
    else
        hit_nxt = 1'b0;
end

// read data registered in the setup cycle so it is valid at the access edge
always @(posedge clock or posedge rst)
begin
    if (rst)
        prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
        prdata <= rd_nxt;
end

endmodule // device_capabilities_reg

// file: testbench/slot_power_link.sv
/* upstream link model: slot power messages as one-cycle strobes.
   assumes the core clock of the port under test. */
`timescale 1ns/1ps
module slot_power_link (
    input wire clock,
    output logic power_msg_valid,
    output logic [7:0] power_msg_value,
    output logic [1:0] power_msg_scale
);
    initial
    begin
        power_msg_valid = 1'b0;
        power_msg_value = 8'h00;
        power_msg_scale = 2'h0;
    end
    // fields mean nothing off the strobe, so scramble them after it
    task automatic send(input logic [7:0] value, input logic [1:0] scale);
        @(posedge clock);
        power_msg_valid <= 1'b1;
        power_msg_value <= value;
        power_msg_scale <= scale;
        @(posedge clock);
        power_msg_valid <= 1'b0;
        power_msg_value <= ~value;
        power_msg_scale <= ~scale;
    endtask
endmodule // slot_power_link

// file: testbench/device_capabilities_asserts.sv
/* checker for the capabilities word; sees only the top ports.
   assumes core clock and active-high async reset. */
`timescale 1ns/1ps
module device_capabilities_asserts #(
    parameter ADDR_WIDTH = 12
) (
    input wire clock,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire power_msg_valid,
    input wire [7:0] power_msg_value,
    input wire [1:0] power_msg_scale,
    input wire is_upstream
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // access phase of a read of the capabilities word
    wire cap_rd = psel && penable && !pwrite && paddr == 'h044;
    reg seen_r;
    reg [9:0] last_r;
    // remembers the latest message the upstream port should hold
    always @(posedge clock or posedge rst)
        if (rst)
            seen_r <= 1'b0;
        else if (power_msg_valid && is_upstream)
        begin
            seen_r <= 1'b1;
            last_r <= {power_msg_scale, power_msg_value};
        end
    phantom_zero_a: assert property (cap_rd |-> prdata[4:3] == 2'h0)
        else $error("phantom field set");
    l0s_latency_zero_a: assert property (cap_rd |-> prdata[8:6] == 3'h0)
        else $error("l0s field set");
    l1_latency_zero_a: assert property (cap_rd |-> prdata[11:9] == 3'h0)
        else $error("l1 field set");
    indicators_zero_a: assert property (cap_rd |-> prdata[14:12] == 3'h0)
        else $error("indicator bits set");
    role_error_set_a: assert property (cap_rd |-> prdata[15])
        else $error("role bit clear");
    reserved_zero_a: assert property (cap_rd |-> {prdata[31:28], prdata[17:16]} == 6'h00)
        else $error("reserved bits set");
    downstream_power_zero_a: assert property (cap_rd && !is_upstream |-> prdata[27:18] == 10'h000)
        else $error("downstream power set");
    power_capture_a: assert property (cap_rd && seen_r |-> prdata[27:18] == last_r)
        else $error("power limit not captured");
    cover property (cap_rd && is_upstream);
    cover property (power_msg_valid && is_upstream);
    cover property (psel && penable && pslverr);
endmodule // device_capabilities_asserts
bind device_capabilities_reg device_capabilities_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_asserts (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
    .power_msg_valid, .power_msg_value, .power_msg_scale, .is_upstream);

// file: testbench/pcie_device_capabilities_reg_test.sv
/* self-checking bench for the capabilities word over APB.
   assumes the link model and the bound checker compile first. */
`timescale 1ns/1ps
module pcie_device_capabilities_reg_test;
    logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF, port_type_pin = 4'h6;
    logic pready, pslverr, is_upstream, power_msg_valid;
    logic [7:0] power_msg_value;
    logic [1:0] power_msg_scale;
    int n_mismatch = 0, tests_run = 0;
    always #5 clock = ~clock;
    slot_power_link u_link (.clock(clock), .power_msg_valid(power_msg_valid),
        .power_msg_value(power_msg_value), .power_msg_scale(power_msg_scale));
    device_capabilities_reg u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_type_pin(port_type_pin),
        .power_msg_valid(power_msg_valid), .power_msg_value(power_msg_value),
        .power_msg_scale(power_msg_scale), .is_upstream(is_upstream));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    // one APB transfer; waits on pready instead of assuming zero wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // strap is set before release so the synchroniser sees it settled
    task automatic restart(input logic [3:0] strap);
        @(posedge clock);
        port_type_pin <= strap;
        rst <= 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        restart(4'h6);
        check({31'h0, is_upstream}, 32'h0);
        apb(0, 12'h044, 0); check(rd, 32'h0000_8024);
        check({31'h0, err}, 32'h0);
        u_link.send(8'hA5, 2'h3);
        apb(0, 12'h044, 0); check(rd, 32'h0000_8024);
        apb(0, 12'h104, 0); check(rd, 32'h0000_0006);
        apb(1, 12'h044, 32'hFFFF_FFD8);
        apb(0, 12'h044, 0); check(rd, 32'h0000_8024);
        apb(1, 12'h100, 32'h1);
        apb(1, 12'h044, 32'hFFFF_FFD8);
        apb(0, 12'h044, 0); check(rd, 32'h0000_8000);
        apb(0, 12'h200, 0); check({rd[31:1], err}, 32'h1);
        restart(4'h5);
        check({31'h0, is_upstream}, 32'h1);
        apb(0, 12'h104, 0); check(rd, 32'h0000_0015);
        // every scale code, with the largest value last
        for (int s = 0; s < 4; s++)
        begin
            u_link.send(8'hFC + s, s[1:0]);
            apb(0, 12'h044, 0); check(rd, 32'h8024 | ((32'hFC + s) << 18) | (s << 26));
        end
        report_and_stop();
    end
    initial
    begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // pcie_device_capabilities_reg_test
